// [bench/swpl_assertions.sv]
`timescale 1ns/1ps
module swpl_checker (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // link
  input wire logic        req_valid,
  input wire logic [7:0]  req_op,
  input wire logic        rsp_valid,
  input wire logic        rsp_ok,
  input wire logic [23:0] rsp_status,
  input wire logic        wp_n,
  input wire logic        power_cycle
);
  logic [7:0] lop, p1, p2;
  logic       wp_q, sus_m, wel_m, otp_m;
  logic [2:0] lb_m;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lop <= 8'h00;
      wp_q <= 1'b1;
    end else if (req_valid) begin
      lop <= req_op;
      wp_q <= wp_n;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sus_m, wel_m, otp_m, lb_m, p1, p2} <= '0;
    end else if (power_cycle) begin
      {sus_m, wel_m, p1, p2} <= '0;
    end else if (rsp_valid) begin
      p1 <= lop;
      p2 <= p1;
      lb_m <= lb_m | rsp_status[13:11];
      if (lop == swpl_pkg::OP_SUSPEND) sus_m <= 1'b1;
      if (lop == swpl_pkg::OP_RESUME) sus_m <= 1'b0;
      if (lop == swpl_pkg::OP_WREN) wel_m <= wel_m | rsp_ok;
      else if (lop inside {8'h01, 8'h02, 8'h04, 8'h20, 8'hd8, 8'hc7, 8'h42, 8'h44}) wel_m <= 1'b0;
      if (lop == swpl_pkg::OP_WRSR && rsp_ok && p1 == swpl_pkg::OP_OTP_B && p2 == swpl_pkg::OP_OTP_A) otp_m <= 1'b1;
    end
  end
  sequence s_wrsr;
    rsp_valid && lop == swpl_pkg::OP_WRSR;
  endsequence
  a_answer_next: assert property (req_valid |=> rsp_valid && !req_valid)
    else $error("late answer");
  a_reserved_zero: assert property (rsp_valid |-> (rsp_status & ~swpl_pkg::SR_USED_MASK) == 24'h0)
    else $error("reserved bit set");
  a_wel_track: assert property (rsp_valid |-> rsp_status[swpl_pkg::SB_WEL] == wel_m)
    else $error("latch wrong");
  a_sus_track: assert property (rsp_valid |-> rsp_status[swpl_pkg::SB_SUS] == sus_m)
    else $error("suspend flag wrong");
  a_lb_sticky: assert property (rsp_valid |-> (rsp_status[13:11] & lb_m) == lb_m)
    else $error("security lock cleared");
  a_wrsr_wel: assert property (s_wrsr ##0 rsp_ok |-> rsp_status[swpl_pkg::SB_WEL])
    else $error("write without latch");
  a_pin_blocks: assert property (s_wrsr ##0 (rsp_status[7] && !rsp_status[9] && !wp_q) |-> !rsp_ok)
    else $error("write with pin low");
  a_srl_blocks: assert property (s_wrsr ##0 rsp_status[swpl_pkg::SB_SRL] |-> !rsp_ok)
    else $error("write while locked");
  a_otp_blocks: assert property (s_wrsr ##0 otp_m |-> !rsp_ok)
    else $error("write after otp lock");
endmodule

// [bench/tb_status_write_protect_logic.sv]
`timescale 1ns/1ps
module tb_status_write_protect_logic;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, chk_q, quad_en, hold_en, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  pct, pct_tab [4];
  logic [31:0] exp_q [$];
  logic [23:0] s;
  int          bad_count, check_count;
  swpl_link_if link ();
  swpl_host swpl_host_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .link);
  swpl_device swpl_device_inst (.pclk, .presetn, .link, .quad_lines_en(quad_en), .hold_en,
    .output_strength(), .drive_percent(pct), .exec_valid(), .exec_op(), .exec_addr(), .exec_len());
  swpl_checker swpl_checker_inst (.pclk, .presetn, .req_valid(link.req_valid),
    .req_op(link.req_op), .rsp_valid(link.rsp_valid), .rsp_ok(link.rsp_ok), .rsp_status(link.rsp_status),
    .wp_n(link.wp_n), .power_cycle(link.power_cycle));
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, want, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; chk_q <= c;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin bad_count++; close_out(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0; chk_q <= 1'b0;
    @(posedge pclk);
  endtask
  task op(input logic [7:0] o, input logic [23:0] a, input logic [23:0] l, input logic [23:0] d);
    int n;
    n = 0;
    apb(1'b1, swpl_pkg::OFF_ADDR, {8'h00, a}, 1'b0);
    apb(1'b1, swpl_pkg::OFF_LEN, {8'h00, l}, 1'b0);
    apb(1'b1, swpl_pkg::OFF_WDATA, {8'h00, d}, 1'b0);
    apb(1'b1, swpl_pkg::OFF_CMD, {24'h0, o}, 1'b0);
    do begin apb(1'b0, swpl_pkg::OFF_STATUS, 32'h0, 1'b0); n++; end while (rd[0] !== 1'b0 && n < 40);
    if (rd[0] !== 1'b0) begin bad_count++; close_out(); end
  endtask
  task okq(input logic e); exp_q.push_back({30'h0, e, 1'b0}); apb(1'b0, swpl_pkg::OFF_STATUS, 32'h0, 1'b1); endtask
  task wren; op(swpl_pkg::OP_WREN, 24'h0, 24'h0, 24'h0); endtask
  task st(input logic [23:0] e);
    op(swpl_pkg::OP_RDSR, 24'h0, 24'h0, 24'h0);
    exp_q.push_back({8'h00, e});
    apb(1'b0, swpl_pkg::OFF_RDATA, 32'h0, 1'b1);
  endtask
  task wsr(input logic [23:0] d, input logic e); wren(); op(swpl_pkg::OP_WRSR, 24'h0, 24'h0, d); okq(e); endtask
  task ctrl(input logic [3:0] c); apb(1'b1, swpl_pkg::OFF_CTRL, {28'h0, c}, 1'b0); endtask
  task prot(input logic [23:0] w, input logic [23:0] a, input logic [23:0] l, input logic e);
    wsr(w, 1'b1);
    wren();
    op(swpl_pkg::OP_PROG, a, l, 24'h0);
    okq(e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) if (psel && penable && pready === 1'b1 && chk_q) chk("prdata", prdata, exp_q.pop_front());
  initial begin pclk = 1'b0; forever #12.5 pclk = ~pclk; end
  initial begin
    {presetn, psel, penable, pwrite, chk_q, paddr, pwdata} = '0;
    pct_tab = '{swpl_pkg::DRV_PCT_0, swpl_pkg::DRV_PCT_1, swpl_pkg::DRV_PCT_2, swpl_pkg::DRV_PCT_3};
    rd = $urandom(32'h74e58e96);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    st(24'h600000);
    op(swpl_pkg::OP_WRSR, 24'h0, 24'h0, 24'h000004); okq(1'b0);
    ctrl(4'h0);
    for (int i = 0; i < 4; i++) begin
      s = {1'b0, 2'(i), 21'h0} | (24'($urandom) & ~swpl_pkg::SR_USED_MASK);
      wsr(s, 1'b1);
      st({1'b0, 2'(i), 21'h0});
      chk("drive", {25'h0, pct}, {25'h0, pct_tab[i]});
    end
    prot(24'h600004, 24'h3f0000, 24'h1, 1'b0);
    prot(24'h600004, 24'h3effff, 24'h1, 1'b1);
    prot(24'h600004, 24'h3effff, 24'h2, 1'b0);
    prot(24'h604004, 24'h3f0000, 24'h1, 1'b1);
    prot(24'h604004, 24'h000000, 24'h1, 1'b0);
    prot(24'h600064, 24'h000fff, 24'h1, 1'b0);
    prot(24'h600064, 24'h001000, 24'h1, 1'b1);
    prot(24'h60001c, 24'h000000, 24'h1, 1'b0);
    prot(24'h640000, 24'h100000, 24'h1, 1'b0);
    wren(); op(swpl_pkg::OP_UNLOCK, 24'h100000, 24'h0, 24'h0);
    op(swpl_pkg::OP_PROG, 24'h100000, 24'h1, 24'h0); okq(1'b1);
    ctrl(4'h8); wren(); op(swpl_pkg::OP_PROG, 24'h100000, 24'h1, 24'h0); okq(1'b0);
    wsr(24'h600000, 1'b1);
    op(swpl_pkg::OP_SUSPEND, 24'h0, 24'h0, 24'h0); st(24'h608000);
    op(swpl_pkg::OP_RESUME, 24'h0, 24'h0, 24'h0); st(24'h600000);
    op(swpl_pkg::OP_SUSPEND, 24'h0, 24'h0, 24'h0); ctrl(4'h8); st(24'h600000);
    wsr(24'h600080, 1'b1); wsr(24'h600000, 1'b0);
    ctrl(4'h1); wsr(24'h600280, 1'b1);
    chk("hold", {30'h0, quad_en, hold_en}, 32'h2);
    ctrl(4'h0); wsr(24'h600080, 1'b1);
    chk("hold", {30'h0, quad_en, hold_en}, 32'h1);
    ctrl(4'h1); wsr(24'h600880, 1'b1); wsr(24'h600080, 1'b1); st(24'h600880);
    wren(); op(swpl_pkg::OP_SECR_PROG, 24'h001000, 24'h1, 24'h0); okq(1'b0);
    wren(); op(swpl_pkg::OP_SECR_PROG, 24'h002000, 24'h1, 24'h0); okq(1'b1);
    wsr(24'h600980, 1'b1); wsr(24'h600880, 1'b0);
    ctrl(4'h9); st(24'h600880); wsr(24'h600880, 1'b1);
    ctrl(4'h5); wsr(24'h600880, 1'b1); ctrl(4'hd); wsr(24'h600880, 1'b0);
    apb(1'b0, 8'h1c, 32'h0, 1'b0); chk("pslverr", {31'h0, err}, 32'h1);
    close_out();
  end
endmodule

// [verilog/swpl_device.sv]
`timescale 1ns/1ps
// Behaviour
// [RULE1] no protect bits: latch alone allows write
// [RULE2] hardware protect, pin low: reject writes
// [RULE3] hardware protect, pin high: latch allows write
// [RULE4] power-cycle lock refuses writes until power-cycle
// [RULE5] pin gates only while quad lines off
// [RULE6] AAh 55h prefix locks status forever; with CTRL_AUTO_WE the host sends WREN after 55h, so no lock
// [RULE7] suspend instruction sets suspend flag
// [RULE8] resume or power-cycle clears suspend flag
// [RULE9] three security locks default 0, settable individually
// [RULE10] security locks sticky; locked register refuses changes
// [RULE11] quad enable picks hold or quad lines
// [RULE12] scheme select picks range bits or locks
// [RULE13] individual locks come up locked
// [RULE14] two-bit code sets read drive strength
// [RULE15] reserved bits ignore writes, host disregards them
// [RULE16] block codes protect 64KB up to all
// [RULE17] sector mode protects 4KB up to 32KB
// [RULE18] program/erase touching protection is dropped
// [RULE19] complement bit inverts protected range
// [RULE20] latch cleared on power-up and after writes
// [RULE21] full address and length checked first
module swpl_device (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // link to host
  swpl_link_if.device     link,
  // pin use and drive
  output logic            quad_lines_en,
  output logic            hold_en,
  output logic [1:0]      output_strength,
  output logic [6:0]      drive_percent,
  // accepted array and security register operations
  output logic            exec_valid,
  output logic [7:0]      exec_op,
  output logic [23:0]     exec_addr,
  output logic [23:0]     exec_len
);
  localparam int NUM_UNITS = swpl_pkg::NUM_UNITS;
  logic                 write_enable_latch;
  logic [2:0]           block_protect_reg;
  logic                 top_bottom_select;
  logic                 small_granule_select;
  logic                 status_hw_protect_enable;
  logic                 status_lock_until_powercycle;
  logic                 otp_locked_reg;
  logic                 quad_pins_enable;
  logic [2:0]           security_lock_reg;
  logic                 complement_protect;
  logic                 erase_program_paused_flag;
  logic                 protect_scheme_select;
  logic [1:0]           strength_reg;
  logic [1:0]           prefix_reg;
  logic [NUM_UNITS-1:0] unit_lock_reg;
  logic [23:0]          status_word;
  logic                 sr_write_ok;
  logic                 range_hit;
  logic                 lock_hit;
  logic                 array_op;
  logic                 secr_op;
  logic                 op_allowed;
  logic [1:0]           secr_sel;
  logic [24:0]          req_end;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [24:0] unit_base(input int i);
    if (i < swpl_pkg::EDGE_SECTORS)
      unit_base = 25'(i) * swpl_pkg::SECTOR_BYTES;
    else if (i < swpl_pkg::EDGE_SECTORS + swpl_pkg::MID_BLOCKS)
      unit_base = 25'(i - swpl_pkg::EDGE_SECTORS + 1) * swpl_pkg::BLOCK_BYTES;
    else
      unit_base = swpl_pkg::TOP_BLK_BASE
                + 25'(i - swpl_pkg::EDGE_SECTORS - swpl_pkg::MID_BLOCKS) * swpl_pkg::SECTOR_BYTES;
  endfunction

  function automatic logic [24:0] unit_size(input int i);
    if (i < swpl_pkg::EDGE_SECTORS || i >= swpl_pkg::EDGE_SECTORS + swpl_pkg::MID_BLOCKS)
      unit_size = swpl_pkg::SECTOR_BYTES;
    else
      unit_size = swpl_pkg::BLOCK_BYTES;
  endfunction

  function automatic logic [6:0] drive_pct(input logic [1:0] code);
    unique case (code)
      2'h0: drive_pct = swpl_pkg::DRV_PCT_0;
      2'h1: drive_pct = swpl_pkg::DRV_PCT_1;
      2'h2: drive_pct = swpl_pkg::DRV_PCT_2;
      2'h3: drive_pct = swpl_pkg::DRV_PCT_3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign status_word = {1'b0, strength_reg, 2'h0, protect_scheme_select, 2'h0,
                        erase_program_paused_flag, complement_protect, security_lock_reg, 1'b0,
                        quad_pins_enable, status_lock_until_powercycle, status_hw_protect_enable,
                        small_granule_select, top_bottom_select, block_protect_reg,
                        write_enable_latch, 1'b0};

  always_comb begin
    sr_write_ok = write_enable_latch;                                         // see [RULE1]
    if (status_hw_protect_enable && !quad_pins_enable && !link.wp_n)          // see [RULE5]
      sr_write_ok = 1'b0;                                                     // see [RULE2] see [RULE3]
    if (status_lock_until_powercycle || otp_locked_reg)
      sr_write_ok = 1'b0;                                                     // see [RULE4] see [RULE6]
  end

  // range checked over whole request span
  always_comb begin
    logic [24:0] sz;
    logic [24:0] lo;
    logic [24:0] hi;
    sz = '0;
    if (block_protect_reg == 3'h7)
      sz = swpl_pkg::ARRAY_BYTES;                                             // see [RULE16]
    else if (block_protect_reg != 3'h0 && !small_granule_select)
      sz = swpl_pkg::BLOCK_BYTES << (block_protect_reg - 3'h1);               // see [RULE16]
    else if (block_protect_reg != 3'h0)
      sz = (block_protect_reg >= 3'h4) ? swpl_pkg::SMALL_MAX
                                       : swpl_pkg::SECTOR_BYTES << (block_protect_reg - 3'h1); // see [RULE17]
    lo = top_bottom_select ? 25'h0 : swpl_pkg::ARRAY_BYTES - sz;
    hi = top_bottom_select ? sz : swpl_pkg::ARRAY_BYTES;
    req_end = {1'b0, link.req_addr} + {1'b0, link.req_len};                   // see [RULE21]
    if (complement_protect)
      range_hit = ({1'b0, link.req_addr} < lo) || (req_end > hi);             // see [RULE19]
    else
      range_hit = ({1'b0, link.req_addr} < hi) && (req_end > lo);
  end

  always_comb begin
    lock_hit = 1'b0;
    for (int i = 0; i < NUM_UNITS; i++) begin
      if (unit_lock_reg[i] && {1'b0, link.req_addr} < unit_base(i) + unit_size(i)
          && req_end > unit_base(i))
        lock_hit = 1'b1;
    end
  end

  assign array_op   = link.req_op == swpl_pkg::OP_PROG || link.req_op == swpl_pkg::OP_SECT_ERA
                   || link.req_op == swpl_pkg::OP_BLK_ERA || link.req_op == swpl_pkg::OP_CHIP_ERA;
  assign secr_op    = link.req_op == swpl_pkg::OP_SECR_PROG || link.req_op == swpl_pkg::OP_SECR_ERA;
  assign secr_sel   = link.req_addr[swpl_pkg::SECR_SEL_LSB +: 2];

  always_comb begin
    op_allowed = 1'b0;
    if (array_op)
      op_allowed = write_enable_latch && link.req_len != 24'h0
                && !(protect_scheme_select ? lock_hit : range_hit);           // see [RULE12] see [RULE18]
    else if (secr_op)
      op_allowed = write_enable_latch && secr_sel != 2'h0
                && !security_lock_reg[secr_sel - 2'h1];                       // see [RULE10]
    else if (link.req_op == swpl_pkg::OP_WRSR)
      op_allowed = sr_write_ok;
    else
      op_allowed = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_enable_latch <= 1'b0;
    end else if (link.power_cycle) begin
      write_enable_latch <= 1'b0;                                             // see [RULE20]
    end else if (link.req_valid) begin
      if (link.req_op == swpl_pkg::OP_WREN)
        write_enable_latch <= 1'b1;
      else if (link.req_op == swpl_pkg::OP_WRDI || link.req_op == swpl_pkg::OP_WRSR || array_op || secr_op)
        write_enable_latch <= 1'b0;                                           // see [RULE20]
    end
  end

  // a prefix only counts when the write follows it directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prefix_reg <= 2'h0;
    end else if (link.power_cycle) begin
      prefix_reg <= 2'h0;
    end else if (link.req_valid) begin
      if (link.req_op == swpl_pkg::OP_OTP_A)
        prefix_reg <= 2'h1;
      else if (link.req_op == swpl_pkg::OP_OTP_B && prefix_reg == 2'h1)
        prefix_reg <= 2'h2;
      else
        prefix_reg <= 2'h0;
    end
  end

  // non-volatile bits keep their value across a power cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_protect_reg        <= 3'h0;
      top_bottom_select        <= 1'b0;
      small_granule_select     <= 1'b0;
      status_hw_protect_enable <= 1'b0;
      quad_pins_enable         <= 1'b0;
      security_lock_reg        <= 3'h0;
      complement_protect       <= 1'b0;
      protect_scheme_select    <= 1'b0;
      strength_reg             <= swpl_pkg::DRV_RESET;                        // see [RULE14]
      otp_locked_reg           <= 1'b0;
    end else if (link.req_valid && link.req_op == swpl_pkg::OP_WRSR && sr_write_ok && !link.power_cycle) begin
      block_protect_reg        <= link.req_wdata[swpl_pkg::SB_BP0 +: 3];
      top_bottom_select        <= link.req_wdata[swpl_pkg::SB_TB];
      small_granule_select     <= link.req_wdata[swpl_pkg::SB_SEC];
      status_hw_protect_enable <= link.req_wdata[swpl_pkg::SB_SRP];
      quad_pins_enable         <= link.req_wdata[swpl_pkg::SB_QE];
      security_lock_reg        <= security_lock_reg | link.req_wdata[swpl_pkg::SB_LB1 +: 3]; // see [RULE9] see [RULE10]
      complement_protect       <= link.req_wdata[swpl_pkg::SB_CMP];
      protect_scheme_select    <= link.req_wdata[swpl_pkg::SB_WPS];
      strength_reg             <= link.req_wdata[swpl_pkg::SB_DRV +: 2];
      if (prefix_reg == 2'h2)
        otp_locked_reg <= 1'b1;                                               // see [RULE6]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_lock_until_powercycle <= 1'b0;
    end else if (link.power_cycle) begin
      status_lock_until_powercycle <= 1'b0;                                   // see [RULE4]
    end else if (link.req_valid && link.req_op == swpl_pkg::OP_WRSR && sr_write_ok) begin
      status_lock_until_powercycle <= link.req_wdata[swpl_pkg::SB_SRL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_program_paused_flag <= 1'b0;
    end else if (link.power_cycle) begin
      erase_program_paused_flag <= 1'b0;                                      // see [RULE8]
    end else if (link.req_valid && link.req_op == swpl_pkg::OP_SUSPEND) begin
      erase_program_paused_flag <= 1'b1;                                      // see [RULE7]
    end else if (link.req_valid && link.req_op == swpl_pkg::OP_RESUME) begin
      erase_program_paused_flag <= 1'b0;                                      // see [RULE8]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_lock_reg <= '1;                                                    // see [RULE13]
    end else if (link.power_cycle) begin
      unit_lock_reg <= '1;                                                    // see [RULE13]
    end else if (link.req_valid && link.req_op == swpl_pkg::OP_UNLOCK && write_enable_latch) begin
      for (int i = 0; i < NUM_UNITS; i++) begin
        if ({1'b0, link.req_addr} >= unit_base(i) && {1'b0, link.req_addr} < unit_base(i) + unit_size(i))
          unit_lock_reg[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.rsp_valid  <= 1'b0;
      link.rsp_ok     <= 1'b0;
      link.rsp_status <= 24'h0;
      exec_valid      <= 1'b0;
      exec_op         <= 8'h0;
      exec_addr       <= 24'h0;
      exec_len        <= 24'h0;
    end else begin
      link.rsp_valid  <= link.req_valid;
      link.rsp_ok     <= link.req_valid && op_allowed;
      link.rsp_status <= status_word & swpl_pkg::SR_USED_MASK;                // see [RULE15]
      exec_valid      <= link.req_valid && op_allowed && (array_op || secr_op);
      if (link.req_valid) begin
        exec_op   <= link.req_op;
        exec_addr <= link.req_addr;
        exec_len  <= link.req_len;
      end
    end
  end

  assign quad_lines_en   = quad_pins_enable;                                  // see [RULE11]
  assign hold_en         = !quad_pins_enable;                                 // see [RULE11]
  assign output_strength = strength_reg;
  assign drive_percent   = drive_pct(strength_reg);                           // see [RULE14]
endmodule

// [verilog/swpl_host.sv]
`timescale 1ns/1ps
module swpl_host (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link to device
  swpl_link_if.host        link
);
  typedef enum logic [2:0] {H_IDLE, H_PRE_A, H_PRE_B, H_WREN, H_MAIN} swpl_hstate_e;

  swpl_hstate_e state_reg;
  logic         wait_reg;
  logic [7:0]   op_reg;
  logic [23:0]  addr_reg;
  logic [23:0]  len_reg;
  logic [23:0]  wdata_reg;
  logic [23:0]  rdata_reg;
  logic [3:0]   ctrl_reg;
  logic         ok_reg;
  logic         apb_wr;
  logic         mapped;
  logic         start;

  assign apb_wr  = psel && penable && pwrite;
  assign mapped  = paddr inside {swpl_pkg::OFF_CMD, swpl_pkg::OFF_ADDR, swpl_pkg::OFF_LEN,
                                 swpl_pkg::OFF_WDATA, swpl_pkg::OFF_STATUS, swpl_pkg::OFF_RDATA,
                                 swpl_pkg::OFF_CTRL};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign start   = apb_wr && paddr == swpl_pkg::OFF_CMD && state_reg == H_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg    <= 8'h0;
      addr_reg  <= 24'h0;
      len_reg   <= 24'h0;
      wdata_reg <= 24'h0;
      ctrl_reg  <= swpl_pkg::CTRL_RESET;
    end else begin
      ctrl_reg[swpl_pkg::CTRL_PWR] <= 1'b0;
      if (apb_wr && paddr == swpl_pkg::OFF_CTRL)
        ctrl_reg <= pwdata[3:0];
      if (start)
        op_reg <= pwdata[7:0];
      if (apb_wr && paddr == swpl_pkg::OFF_ADDR)
        addr_reg <= pwdata[23:0];
      if (apb_wr && paddr == swpl_pkg::OFF_LEN)
        len_reg <= pwdata[23:0];
      if (apb_wr && paddr == swpl_pkg::OFF_WDATA)
        wdata_reg <= pwdata[23:0];
    end
  end

  always_comb begin
    unique case (paddr)
      swpl_pkg::OFF_CMD:    prdata = {24'h0, op_reg};
      swpl_pkg::OFF_ADDR:   prdata = {8'h0, addr_reg};
      swpl_pkg::OFF_LEN:    prdata = {8'h0, len_reg};
      swpl_pkg::OFF_WDATA:  prdata = {8'h0, wdata_reg};
      swpl_pkg::OFF_STATUS: prdata = {30'h0, ok_reg, state_reg != H_IDLE};
      swpl_pkg::OFF_RDATA:  prdata = {8'h0, rdata_reg};
      swpl_pkg::OFF_CTRL:   prdata = {28'h0, ctrl_reg};
      default:              prdata = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // one instruction in flight; each step waits for its answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= H_IDLE;
      wait_reg  <= 1'b0;
      ok_reg    <= 1'b0;
      rdata_reg <= 24'h0;
    end else if (start) begin
      if (pwdata[7:0] == swpl_pkg::OP_WRSR && ctrl_reg[swpl_pkg::CTRL_OTP])
        state_reg <= H_PRE_A;                                                 // see [RULE6]
      else if (pwdata[7:0] == swpl_pkg::OP_WRSR && ctrl_reg[swpl_pkg::CTRL_AUTO_WE])
        state_reg <= H_WREN;                                                  // see [RULE1] see [RULE3]
      else
        state_reg <= H_MAIN;
    end else if (state_reg != H_IDLE) begin
      if (!wait_reg) begin
        wait_reg <= 1'b1;
      end else if (link.rsp_valid) begin
        wait_reg <= 1'b0;
        unique case (state_reg)
          H_PRE_A: state_reg <= H_PRE_B;
          H_PRE_B: state_reg <= ctrl_reg[swpl_pkg::CTRL_AUTO_WE] ? H_WREN : H_MAIN;
          H_WREN:  state_reg <= H_MAIN;
          H_MAIN:  state_reg <= H_IDLE;
          default: state_reg <= H_IDLE;
        endcase
        if (state_reg == H_MAIN) begin
          ok_reg    <= link.rsp_ok;
          rdata_reg <= link.rsp_status & swpl_pkg::SR_USED_MASK;              // see [RULE15]
        end
      end
    end
  end

  always_comb begin
    link.req_valid = state_reg != H_IDLE && !wait_reg;
    unique case (state_reg)
      H_PRE_A: link.req_op = swpl_pkg::OP_OTP_A;
      H_PRE_B: link.req_op = swpl_pkg::OP_OTP_B;
      H_WREN:  link.req_op = swpl_pkg::OP_WREN;
      default: link.req_op = op_reg;
    endcase
  end

  assign link.req_addr    = addr_reg;
  assign link.req_len     = len_reg;
  assign link.req_wdata   = wdata_reg;
  assign link.wp_n        = ctrl_reg[swpl_pkg::CTRL_WP];
  assign link.power_cycle = ctrl_reg[swpl_pkg::CTRL_PWR];
endmodule

// [verilog/swpl_link_if.sv]
`timescale 1ns/1ps
interface swpl_link_if;
  logic        req_valid;
  logic [7:0]  req_op;
  logic [23:0] req_addr;
  logic [23:0] req_len;
  logic [23:0] req_wdata;
  logic        rsp_valid;
  logic        rsp_ok;
  logic [23:0] rsp_status;
  logic        wp_n;
  logic        power_cycle;

  modport device (
    input  req_valid, req_op, req_addr, req_len, req_wdata, wp_n, power_cycle,
    output rsp_valid, rsp_ok, rsp_status
  );
  modport host (
    output req_valid, req_op, req_addr, req_len, req_wdata, wp_n, power_cycle,
    input  rsp_valid, rsp_ok, rsp_status
  );
endinterface

// [verilog/swpl_pkg.sv]
package swpl_pkg;
  // instruction codes
  localparam logic [7:0] OP_WREN      = 8'h06;
  localparam logic [7:0] OP_WRDI      = 8'h04;
  localparam logic [7:0] OP_WRSR      = 8'h01;
  localparam logic [7:0] OP_RDSR      = 8'h05;
  localparam logic [7:0] OP_PROG      = 8'h02;
  localparam logic [7:0] OP_SECT_ERA  = 8'h20;
  localparam logic [7:0] OP_BLK_ERA   = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERA  = 8'hc7;
  localparam logic [7:0] OP_SUSPEND   = 8'h75;
  localparam logic [7:0] OP_RESUME    = 8'h7a;
  localparam logic [7:0] OP_UNLOCK    = 8'h39;
  localparam logic [7:0] OP_SECR_PROG = 8'h42;
  localparam logic [7:0] OP_SECR_ERA  = 8'h44;
  localparam logic [7:0] OP_OTP_A     = 8'haa;
  localparam logic [7:0] OP_OTP_B     = 8'h55;
  // status word bit positions
  localparam int SB_WEL = 1;
  localparam int SB_BP0 = 2;
  localparam int SB_TB  = 5;
  localparam int SB_SEC = 6;
  localparam int SB_SRP = 7;
  localparam int SB_SRL = 8;
  localparam int SB_QE  = 9;
  localparam int SB_LB1 = 11;
  localparam int SB_CMP = 14;
  localparam int SB_SUS = 15;
  localparam int SB_WPS = 18;
  localparam int SB_DRV = 21;
  // bits that carry meaning; all others are reserved and read 0
  localparam logic [23:0] SR_USED_MASK = 24'h64fbfe;
  localparam logic [1:0]  DRV_RESET    = 2'h3;
  // array geometry, byte sizes
  localparam logic [24:0] ARRAY_BYTES  = 25'h0400000;
  localparam logic [24:0] BLOCK_BYTES  = 25'h0010000;
  localparam logic [24:0] SECTOR_BYTES = 25'h0001000;
  localparam logic [24:0] SMALL_MAX    = 25'h0008000;
  localparam logic [24:0] TOP_BLK_BASE = 25'h03f0000;
  localparam int          EDGE_SECTORS = 16;
  localparam int          MID_BLOCKS   = 62;
  localparam int          NUM_UNITS    = 94;
  localparam int          SECR_SEL_LSB = 12;
  // drive strength in percent per code
  localparam logic [6:0] DRV_PCT_0 = 7'd100;
  localparam logic [6:0] DRV_PCT_1 = 7'd75;
  localparam logic [6:0] DRV_PCT_2 = 7'd50;
  localparam logic [6:0] DRV_PCT_3 = 7'd25;
  // controller register offsets
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_LEN    = 8'h08;
  localparam logic [7:0] OFF_WDATA  = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_RDATA  = 8'h14;
  localparam logic [7:0] OFF_CTRL   = 8'h18;
  localparam int CTRL_WP      = 0;
  localparam int CTRL_AUTO_WE = 1;
  localparam int CTRL_OTP     = 2;
  localparam int CTRL_PWR     = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1;
endpackage
